// ===== src/psi_pkg.sv
// Package holding the register map, reset values, states and carriers of the status block.
package psi_pkg;

   // -------------------------------------------------------------------------
   // Register offsets
   // -------------------------------------------------------------------------
   localparam logic [7:0] OFF_SYSTEM_STATUS = 8'h02;
   localparam logic [7:0] OFF_READ_CLEAR_CFG = 8'h15;
   localparam int          NUM_FLAG_REGS = 5;

   // Entry order: supply, battery, charger, converter, system.
   localparam logic [4:0][7:0] OFF_FLAGS = {8'h07, 8'h06, 8'h05, 8'h04, 8'h03};
   localparam logic [4:0][7:0] OFF_MASKS = {8'h0C, 8'h0B, 8'h0A, 8'h09, 8'h08};

   // Implemented bits of each flag and mask register; other bits read zero.
   localparam logic [4:0][7:0] FLAG_VALID = {8'hFF, 8'h07, 8'h7F, 8'hFF, 8'h3F};
   localparam logic [4:0][7:0] MASK_RESET = {8'hFF, 8'h07, 8'h7F, 8'hFF, 8'h3F};

   // -------------------------------------------------------------------------
   // Field positions
   // -------------------------------------------------------------------------
   localparam int POS_CONVERTER_GOOD   = 6;
   localparam int POS_CHARGE_STATE_LO  = 4;
   localparam int POS_POWER_CYCLE_SEEN = 1;
   localparam int POS_MODE_PIN_LEVEL   = 0;
   localparam int POS_READ_CLEAR_INHIBIT = 2;
   localparam int POS_MODE_PIN_FALL    = 6;
   localparam int POS_MODE_PIN_RISE    = 5;
   localparam int POS_DIE_OVERHEAT     = 3;
   localparam int IDX_SYSTEM_FLAGS     = 4;

   localparam logic [6:0] DEVICE_ADDR_RESET = 7'h68;
   localparam logic [3:0] BITS_PER_BYTE    = 4'h8;
   localparam logic [3:0] LAST_TX_BIT      = 4'h7;

   // -------------------------------------------------------------------------
   // Types
   // -------------------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE  = 3'b000,
      ST_RX    = 3'b001,
      ST_ACK   = 3'b010,
      ST_TX    = 3'b011,
      ST_TXACK = 3'b100
   } psi_bus_state_e;

   typedef enum logic [1:0]
   {
      PH_ADDR = 2'b00,
      PH_PTR  = 2'b01,
      PH_DATA = 2'b10
   } psi_phase_e;

   typedef struct packed
   {
      logic [7:0] system;
      logic [7:0] converter;
      logic [7:0] charger;
      logic [7:0] battery;
      logic [7:0] supply;
   } psi_events_s;

   typedef struct packed
   {
      logic [1:0] charge_state;
      logic       converter_good;
      logic       power_cycle_pulse;
      logic       mode_pin_level;
   } psi_status_s;

endpackage

// ===== src/psi_flag_bank.sv
// One register of sticky event flags with clear on read and a masked pending output.
`timescale 1ns/10ps
module psi_flag_bank #(
   parameter logic [7:0] VALID = 8'hFF
) (
   input  wire logic       i_clock,
   input  wire logic       i_srst,
   input  wire logic [7:0] i_set,
   input  wire logic       i_read_clear,
   input  wire logic [7:0] i_mask,
   output logic      [7:0] o_flags,
   output logic            o_pending
);

   typedef struct packed
   {
      logic [7:0] flags;
      logic       pending;
   } psi_bank_s;

   psi_bank_s q;
   psi_bank_s d;

   // -------------------------------------------------------------------------
   // Flag update
   // -------------------------------------------------------------------------
   // A set arriving in the cycle of a read clear survives, so no event is lost.
   always_comb
   begin
      d = q;
      if (i_read_clear)
      begin
         d.flags = i_set & VALID;
      end
      else
      begin
         d.flags = (q.flags | i_set) & VALID;
      end
      d.pending = |(d.flags & ~i_mask);
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_flags   = q.flags;
   assign o_pending = q.pending;

   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   property p_sticky;
      (q.flags != 8'h00) && !i_read_clear |=> ((q.flags & $past(q.flags)) == $past(q.flags));
   endproperty
   a_sticky: assert property (p_sticky) else $error("Flag dropped without a read.");

   property p_set_lands;
      ((i_set & VALID) != 8'h00) |=> ((q.flags & $past(i_set & VALID)) == $past(i_set & VALID));
   endproperty
   a_set_lands: assert property (p_set_lands) else $error("Event did not latch.");

endmodule

// ===== src/psi_status_irq.sv
// Status, event flags, masks and two-wire serial register access of the power device.
//
// Overview of operation
// - The charger state is read at status bits 5:4 as ready, charging, done or fault.
// - The power-cycle bit at status bit 1 sets on a power cycle and clears once read.
// - The converter power-good level reads live from its input at status bit 6.
// - Status bit 0 shows the mode pin, and its falls and rises latch system flags 6 and 5.
// - Supply flags latch at bits 0 to 5 for overvoltage, lockout, recovery, limit and rail.
// - Thermistor zone flags latch at battery bits 7 to 4 and thermistor-off at charger bit 6.
// - Battery short, overcurrent, supplementing and lockout latch at battery bits 3 to 0.
// - Charger timer, recharge, done, precharge, supplement and sleep latch at bits 5 to 0.
// - Converter undervoltage, overvoltage and overcurrent latch at bits 2 to 0.
// - Plug power cycle, watchdog and overheat latch at system bits 7, 4 and 3.
// - Reset-input long, second wake and first wake timers latch at system bits 2 to 0.
// - Each flag register has a mask register with matching bit positions.
// - Reading a flag register clears it, and reading the status clears bit 1, unless the inhibit bit 2 is set.
// - Every implemented mask bit is one after reset, so every source starts masked.
// - An overheat event sets its flag and, once system mask bit 3 is cleared, drives the fault pin.
`timescale 1ns/10ps
module psi_status_irq #(
   parameter logic [6:0] DEVICE_ADDR = psi_pkg::DEVICE_ADDR_RESET
) (
   input  wire logic                 i_clock,
   input  wire logic                 i_srst,
   input  wire logic                 i_scl,
   input  wire logic                 i_sda,
   input  wire psi_pkg::psi_events_s i_events,
   input  wire psi_pkg::psi_status_s i_status,
   output logic                      o_sda_out,
   output logic                      o_sda_oe,
   output logic                      o_fault_output_pin_n
);

   typedef struct packed
   {
      psi_pkg::psi_bus_state_e st;
      psi_pkg::psi_phase_e     phase;
      logic [3:0]              bitcnt;
      logic [7:0]              shreg;
      logic [7:0]              ptr;
      logic                    rw;
      logic                    acked;
      logic                    scl_q;
      logic                    sda_q;
      logic                    sda_oe;
      logic                    sda_out;
      logic [4:0][7:0]         mask;
      logic                    read_clear_inhibit;
      logic                    power_cycle_seen;
      logic                    mode_q;
      logic                    fault_n;
   } psi_top_s;

   psi_top_s        q;
   psi_top_s        d;
   logic [4:0][7:0] set_v;
   logic [4:0][7:0] flags_v;
   logic [4:0]      pend_v;
   logic [4:0]      rd_clr;
   logic            scl_rise;
   logic            scl_fall;
   logic            bus_start;
   logic            bus_stop;
   logic            tx_load;
   logic            load_next;
   logic            wr_en;
   logic            mode_rise;
   logic            mode_fall;
   logic [7:0]      rd_byte;

   // -------------------------------------------------------------------------
   // Event sources
   // -------------------------------------------------------------------------
   assign mode_rise = i_status.mode_pin_level & ~q.mode_q;
   assign mode_fall = ~i_status.mode_pin_level & q.mode_q;

   assign set_v[0] = i_events.supply;
   assign set_v[1] = i_events.battery;
   assign set_v[2] = i_events.charger;
   assign set_v[3] = i_events.converter;
   assign set_v[4] = {i_events.system[7], mode_fall, mode_rise,
                      i_events.system[4:0]};

   genvar g;
   generate
      for (g = 0; g < psi_pkg::NUM_FLAG_REGS; g = g + 1)
      begin : gen_bank
         psi_flag_bank #(
            .VALID (psi_pkg::FLAG_VALID[g])
         ) u_bank (
            .i_clock      (i_clock),
            .i_srst       (i_srst),
            .i_set        (set_v[g]),
            .i_read_clear (rd_clr[g]),
            .i_mask       (q.mask[g]),
            .o_flags      (flags_v[g]),
            .o_pending    (pend_v[g])
         );
      end
   endgenerate

   // -------------------------------------------------------------------------
   // Read data
   // -------------------------------------------------------------------------
   // Status bits other than power-cycle bit 1 are read live, so a read reports the level at the load edge.
   always_comb
   begin
      rd_byte = 8'h00;
      if (q.ptr == psi_pkg::OFF_SYSTEM_STATUS)
      begin
         rd_byte[psi_pkg::POS_CONVERTER_GOOD] = i_status.converter_good;
         rd_byte[psi_pkg::POS_CHARGE_STATE_LO +: 2] = i_status.charge_state;
         rd_byte[psi_pkg::POS_POWER_CYCLE_SEEN] = q.power_cycle_seen;
         rd_byte[psi_pkg::POS_MODE_PIN_LEVEL] = i_status.mode_pin_level;
      end
      else if (q.ptr == psi_pkg::OFF_READ_CLEAR_CFG)
      begin
         rd_byte[psi_pkg::POS_READ_CLEAR_INHIBIT] = q.read_clear_inhibit;
      end
      for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
      begin
         if (q.ptr == psi_pkg::OFF_FLAGS[i])
         begin
            rd_byte = flags_v[i];
         end
         if (q.ptr == psi_pkg::OFF_MASKS[i])
         begin
            rd_byte = q.mask[i];
         end
      end
   end

   // -------------------------------------------------------------------------
   // Serial slave and register state
   // -------------------------------------------------------------------------
   assign scl_rise  = i_scl & ~q.scl_q;
   assign scl_fall  = ~i_scl & q.scl_q;
   assign bus_start = i_scl & q.scl_q & q.sda_q & ~i_sda;
   assign bus_stop  = i_scl & q.scl_q & ~q.sda_q & i_sda;

   always_comb
   begin
      d         = q;
      d.scl_q   = i_scl;
      d.sda_q   = i_sda;
      d.mode_q  = i_status.mode_pin_level;
      d.sda_out = 1'b0;
      tx_load   = 1'b0;
      load_next = 1'b0;
      wr_en     = 1'b0;
      rd_clr    = '0;
      if (bus_start)
      begin
         d.st     = psi_pkg::ST_RX;
         d.phase  = psi_pkg::PH_ADDR;
         d.bitcnt = 4'h0;
         d.rw     = 1'b0;
         d.sda_oe = 1'b0;
      end
      else if (bus_stop)
      begin
         d.st     = psi_pkg::ST_IDLE;
         d.sda_oe = 1'b0;
      end
      else
      begin
         case (q.st)
            psi_pkg::ST_RX:
            begin
               if (scl_rise)
               begin
                  d.shreg  = {q.shreg[6:0], i_sda};
                  d.bitcnt = q.bitcnt + 4'h1;
               end
               else if (scl_fall && q.bitcnt == psi_pkg::BITS_PER_BYTE)
               begin
                  d.bitcnt = 4'h0;
                  d.st     = psi_pkg::ST_ACK;
                  d.sda_oe = 1'b1;
                  case (q.phase)
                     psi_pkg::PH_ADDR:
                     begin
                        d.rw    = q.shreg[0];
                        d.phase = psi_pkg::PH_PTR;
                        if (q.shreg[7:1] != DEVICE_ADDR)
                        begin
                           d.st     = psi_pkg::ST_IDLE;
                           d.sda_oe = 1'b0;
                        end
                     end
                     psi_pkg::PH_PTR:
                     begin
                        d.ptr   = q.shreg;
                        d.phase = psi_pkg::PH_DATA;
                     end
                     default:
                     begin
                        wr_en = 1'b1;
                        d.ptr = q.ptr + 8'h01;
                     end
                  endcase
               end
            end
            psi_pkg::ST_ACK:
            begin
               if (scl_fall)
               begin
                  if (q.rw)
                  begin
                     load_next = 1'b1;
                  end
                  else
                  begin
                     d.st     = psi_pkg::ST_RX;
                     d.sda_oe = 1'b0;
                  end
               end
            end
            psi_pkg::ST_TX:
            begin
               if (scl_fall)
               begin
                  if (q.bitcnt == psi_pkg::LAST_TX_BIT)
                  begin
                     d.bitcnt = 4'h0;
                     d.st     = psi_pkg::ST_TXACK;
                     d.sda_oe = 1'b0;
                  end
                  else
                  begin
                     d.bitcnt = q.bitcnt + 4'h1;
                     d.shreg  = {q.shreg[6:0], 1'b0};
                     d.sda_oe = ~q.shreg[6];
                  end
               end
            end
            psi_pkg::ST_TXACK:
            begin
               if (scl_rise)
               begin
                  d.acked = ~i_sda;
               end
               else if (scl_fall)
               begin
                  if (q.acked)
                  begin
                     load_next = 1'b1;
                  end
                  else
                  begin
                     d.st = psi_pkg::ST_IDLE;
                  end
               end
            end
            default:
            begin
               d.st = psi_pkg::ST_IDLE;
            end
         endcase
      end
      if (load_next)
      begin
         tx_load  = 1'b1;
         d.shreg  = rd_byte;
         d.ptr    = q.ptr + 8'h01;
         d.st     = psi_pkg::ST_TX;
         d.sda_oe = ~rd_byte[7];
      end
      if (tx_load && !q.read_clear_inhibit)
      begin
         for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
         begin
            rd_clr[i] = (q.ptr == psi_pkg::OFF_FLAGS[i]);
         end
      end
      if (wr_en)
      begin
         for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
         begin
            if (q.ptr == psi_pkg::OFF_MASKS[i])
            begin
               d.mask[i] = q.shreg & psi_pkg::FLAG_VALID[i];
            end
         end
         if (q.ptr == psi_pkg::OFF_READ_CLEAR_CFG)
         begin
            d.read_clear_inhibit = q.shreg[psi_pkg::POS_READ_CLEAR_INHIBIT];
         end
      end
      if (i_status.power_cycle_pulse)
      begin
         d.power_cycle_seen = 1'b1;
      end
      else if (tx_load && !q.read_clear_inhibit && q.ptr == psi_pkg::OFF_SYSTEM_STATUS)
      begin
         d.power_cycle_seen = 1'b0;
      end
      // Pending terms are registered with the flags, so the pin trails the flags by a cycle.
      d.fault_n = ~(|pend_v);
   end

   always_ff @(posedge i_clock)
   begin
      if (i_srst)
      begin
         q         <= '0;
         q.scl_q   <= 1'b1;
         q.sda_q   <= 1'b1;
         q.fault_n <= 1'b1;
         q.mask    <= psi_pkg::MASK_RESET;
      end
      else
      begin
         q <= d;
      end
   end

   assign o_sda_out            = q.sda_out;
   assign o_sda_oe             = q.sda_oe;
   assign o_fault_output_pin_n = q.fault_n;

   // -------------------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------------------
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_srst);

   sequence s_status_load;
      tx_load && q.ptr == psi_pkg::OFF_SYSTEM_STATUS;
   endsequence

   property p_charge_state;
      s_status_load |=> q.shreg[5:4] == $past(i_status.charge_state);
   endproperty
   a_charge_state: assert property (p_charge_state) else $error("Charge state misread.");

   property p_power_cycle;
      i_status.power_cycle_pulse |=> q.power_cycle_seen;
   endproperty
   a_power_cycle: assert property (p_power_cycle) else $error("Power cycle not held.");

   property p_power_cycle_clear;
      s_status_load ##0 !q.read_clear_inhibit ##0 !i_status.power_cycle_pulse
         |=> !q.power_cycle_seen;
   endproperty
   a_power_cycle_clear: assert property (p_power_cycle_clear)
      else $error("Status bit kept.");

   property p_converter_good;
      s_status_load |=> q.shreg[6] == $past(i_status.converter_good) && q.shreg[7] == 1'b0;
   endproperty
   a_converter_good: assert property (p_converter_good)
      else $error("Power good misread.");

   property p_mode_rise;
      i_status.mode_pin_level && !q.mode_q |=> flags_v[4][psi_pkg::POS_MODE_PIN_RISE];
   endproperty
   a_mode_rise: assert property (p_mode_rise) else $error("Mode rise not latched.");

   property p_mode_fall;
      !i_status.mode_pin_level && q.mode_q |=> flags_v[4][psi_pkg::POS_MODE_PIN_FALL];
   endproperty
   a_mode_fall: assert property (p_mode_fall) else $error("Mode fall not latched.");

   property p_mask_reset;
      $past(i_srst) |-> q.mask == psi_pkg::MASK_RESET;
   endproperty
   a_mask_reset: assert property (p_mask_reset)
      else $error("Masks not set after reset.");

   property p_overheat_fault;
      i_events.system[psi_pkg::POS_DIE_OVERHEAT] && !q.mask[4][psi_pkg::POS_DIE_OVERHEAT]
         ##1 !q.mask[4][psi_pkg::POS_DIE_OVERHEAT] && !rd_clr[4] |=> ##1 !o_fault_output_pin_n;
   endproperty
   a_overheat_fault: assert property (p_overheat_fault) else $error("Overheat missed.");

   property p_fault_release;
      (pend_v == 5'h00) [*2] |=> o_fault_output_pin_n;
   endproperty
   a_fault_release: assert property (p_fault_release) else $error("Fault pin stuck.");

endmodule

// ===== verification/psi_host_model.sv
// Behavioural host controller that reads and writes the status block over the serial pins.
`timescale 1ns/10ps
module psi_host_model #(
   parameter logic [6:0] ADDR = psi_pkg::DEVICE_ADDR_RESET
) (
   input  wire logic i_clock,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda
);
   int nacks = 0;

   initial
   begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end

   // Four clocks a phase leaves the device's pin sampling a wide margin.
   task automatic ph();
      repeat (4) @(posedge i_clock);
   endtask

   task automatic start();
      o_sda <= 1'b1;
      ph();
      o_scl <= 1'b1;
      ph();
      o_sda <= 1'b0;
      ph();
      o_scl <= 1'b0;
      ph();
   endtask

   task automatic stop();
      o_sda <= 1'b0;
      ph();
      o_scl <= 1'b1;
      ph();
      o_sda <= 1'b1;
      ph();
   endtask

   // Eight data bits then the acknowledge bit; data only changes while the clock is low.
   task automatic xfer(input logic [7:0] d, input logic ab, output logic [7:0] r,
                       output logic a);
      for (int i = 8; i >= 0; i--)
      begin
         o_sda <= (i == 0) ? ab : d[i - 1];
         ph();
         o_scl <= 1'b1;
         ph();
         if (i == 0)
            a = i_sda;
         else
            r[i - 1] = i_sda;
         o_scl <= 1'b0;
         ph();
      end
   endtask

   task automatic put(input logic [7:0] d);
      logic [7:0] r;
      logic       a;
      xfer(d, 1'b1, r, a);
      if (a !== 1'b0)
         nacks++;
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      start();
      put({ADDR, 1'b0});
      put(p);
      put(d);
      stop();
   endtask

   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic a;
      start();
      put({ADDR, 1'b0});
      put(p);
      start();
      put({ADDR, 1'b1});
      xfer(8'hFF, 1'b1, d, a);
      stop();
   endtask

   // Two-byte read: the first byte is acknowledged so the pointer runs on.
   task automatic rd2(input logic [7:0] p, output logic [7:0] d0, output logic [7:0] d1);
      logic a;
      start();
      put({ADDR, 1'b0});
      put(p);
      start();
      put({ADDR, 1'b1});
      xfer(8'hFF, 1'b0, d0, a);
      xfer(8'hFF, 1'b1, d1, a);
      stop();
   endtask

   task automatic wr2(input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
      start();
      put({ADDR, 1'b0});
      put(p);
      put(d0);
      put(d1);
      stop();
   endtask

   task automatic probe(input logic [6:0] adr, output logic a);
      logic [7:0] r;
      start();
      xfer({adr, 1'b0}, 1'b1, r, a);
      stop();
   endtask
endmodule

// ===== verification/test_psi_status_irq.sv
// Self-checking bench of the status and event-flag block driven by a serial host model.
`timescale 1ns/10ps
module test_psi_status_irq;
   localparam logic [4:0][7:0] fo = psi_pkg::OFF_FLAGS;
   localparam logic [4:0][7:0] mo = psi_pkg::OFF_MASKS;
   localparam logic [7:0]      so = psi_pkg::OFF_SYSTEM_STATUS;

   logic                 clk = 1'b0;
   logic                 srst = 1'b1;
   logic                 scl;
   logic                 host_sda;
   logic                 sda_out;
   logic                 sda_oe;
   logic                 fault_n;
   logic                 sda_line;
   psi_pkg::psi_events_s ev = '0;
   psi_pkg::psi_status_s st = '0;
   int                   fail_count = 0;
   int                   checks_done = 0;

   always #2 clk = ~clk;
   // Open-drain wire with a pull-up: it reads high unless someone pulls it low.
   assign sda_line = host_sda & ~(sda_oe & ~sda_out);

   psi_status_irq uut (
      .i_clock              (clk),
      .i_srst               (srst),
      .i_scl                (scl),
      .i_sda                (sda_line),
      .i_events             (ev),
      .i_status             (st),
      .o_sda_out            (sda_out),
      .o_sda_oe             (sda_oe),
      .o_fault_output_pin_n (fault_n)
   );

   psi_host_model host (
      .i_clock (clk),
      .i_sda   (sda_line),
      .o_scl   (scl),
      .o_sda   (host_sda)
   );

   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic rchk(input string name, input logic [7:0] p, input logic [7:0] exp);
      logic [7:0] v;
      host.rd(p, v);
      check(name, v, exp);
   endtask

   task automatic pulse(input int i, input logic [7:0] p);
      @(posedge clk);
      ev <= psi_pkg::psi_events_s'(40'(p) << (8 * i));
      @(posedge clk);
      ev <= '0;
      repeat (4) @(posedge clk);
   endtask

   task automatic cycle_pulse();
      @(posedge clk);
      st.power_cycle_pulse <= 1'b1;
      @(posedge clk);
      st.power_cycle_pulse <= 1'b0;
   endtask

   task automatic t_reset();
      check("fault idle", 8'(fault_n), 8'h01);
      rchk("status", so, 8'h00);
      rchk("unmapped", 8'h20, 8'h00);
      for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
      begin
         rchk("mask", mo[i], psi_pkg::MASK_RESET[i]);
         rchk("flags", fo[i], 8'h00);
      end
   endtask

   task automatic t_flags();
      logic [7:0] q;
      for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
         for (int k = 0; k < 2; k++)
         begin
            q = (k == 0 ? 8'hA5 : 8'h5A) & psi_pkg::FLAG_VALID[i];
            if (i == psi_pkg::IDX_SYSTEM_FLAGS)
               q = q & 8'h9F;
            pulse(i, q);
            check("masked", 8'(fault_n), 8'h01);
            rchk("flags", fo[i], q);
            rchk("cleared", fo[i], 8'h00);
         end
   endtask

   task automatic t_fault();
      logic [7:0] b;
      host.wr(mo[3], 8'hFF);
      rchk("mask bits", mo[3], 8'h07);
      for (int i = 0; i < psi_pkg::NUM_FLAG_REGS; i++)
      begin
         b = (i == psi_pkg::IDX_SYSTEM_FLAGS) ? 8'h08 : 8'h01;
         host.wr(mo[i], ~b);
         pulse(i, b);
         repeat (20) @(posedge clk);
         check("fault", 8'(fault_n), 8'h00);
         rchk("flags", fo[i], b);
         check("fault freed", 8'(fault_n), 8'h01);
         host.wr(mo[i], psi_pkg::MASK_RESET[i]);
      end
   endtask

   task automatic t_status();
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clk);
         st <= psi_pkg::psi_status_s'({2'(c), c[0], 1'b0, c[1]});
         rchk("status", so, {1'b0, c[0], 2'(c), 3'b000, c[1]});
      end
      rchk("mode rise", fo[4], 8'h20);
      @(posedge clk);
      st <= '0;
      rchk("mode fall", fo[4], 8'h40);
      cycle_pulse();
      rchk("cycle seen", so, 8'h02);
      rchk("cycle read", so, 8'h00);
   endtask

   task automatic t_inhibit();
      host.wr(psi_pkg::OFF_READ_CLEAR_CFG, 8'h04);
      rchk("inhibit", psi_pkg::OFF_READ_CLEAR_CFG, 8'h04);
      pulse(1, 8'h81);
      cycle_pulse();
      for (int k = 0; k < 2; k++)
      begin
         rchk("kept flags", fo[1], 8'h81);
         rchk("kept cycle", so, 8'h02);
      end
      host.wr(psi_pkg::OFF_READ_CLEAR_CFG, 8'h00);
      rchk("flags", fo[1], 8'h81);
      rchk("cleared", fo[1], 8'h00);
   endtask

   task automatic t_refuse();
      logic a;
      host.probe(psi_pkg::DEVICE_ADDR_RESET ^ 7'h01, a);
      check("foreign address", 8'(a), 8'h01);
      check("host nacks", 8'(host.nacks), 8'h00);
   endtask

   task automatic t_burst();
      logic [7:0] v0;
      logic [7:0] v1;
      host.wr2(mo[0], 8'h15, 8'h2A);
      rchk("mask run", mo[0], 8'h15);
      rchk("mask run", mo[1], 8'h2A);
      host.wr2(mo[0], psi_pkg::MASK_RESET[0], psi_pkg::MASK_RESET[1]);
      pulse(0, 8'h21);
      pulse(1, 8'h42);
      host.rd2(fo[0], v0, v1);
      check("run first", v0, 8'h21);
      check("run second", v1, 8'h42);
      rchk("run cleared", fo[0], 8'h00);
      rchk("run cleared", fo[1], 8'h00);
   endtask

   task automatic print_verdict();
      $display("Checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial
   begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_flags();
      t_fault();
      t_status();
      t_inhibit();
      t_burst();
      t_refuse();
      print_verdict();
   end

   // About two and a half times the length of the whole sequence.
   initial
   begin
      repeat (80000) @(posedge clk);
      fail_count++;
      print_verdict();
   end
endmodule
